//--- hdl/afe_cfg_pkg.sv
// Shared constants and types for the front-end configuration link and its controller
// Operation
// - Gain field picks gain 1 through 128
// - Enable code 00 powers down, bypasses amplifier
// - Enable code 01 puts amplifier in path
// - Host never writes enable codes 10, 11
// - Gains 64, 128 use analog 32 plus scaling
// - Bypass allowed only at gain 1
// - Single-ended to negative supply needs bypass
// - Reference chosen by 2-bit select field
// - Reset selects first external reference pair
// - Select code 10 uses internal reference
// - Power code 10 keeps reference always on
// - Power code 01 drops reference in power-down
// - Internal reference off after reset
// - Host keeps reference on with excitation
// - Host waits reference start-up before converting
package afe_cfg_pkg;

	// ************************************************************
	// Device register map
	// ************************************************************
	localparam logic [7:0] GAIN_CFG_OFS = 8'h03;
	localparam logic [7:0] REF_CTRL_OFS = 8'h05;
	localparam logic [7:0] GAIN_CFG_RST = 8'h00;
	localparam logic [7:0] REF_CTRL_RST = 8'h00;
	localparam int GAIN_LSB = 0;
	localparam int AMP_EN_LSB = 3;
	localparam int REF_PWR_LSB = 0;
	localparam int REF_SEL_LSB = 2;

	// ************************************************************
	// Field codes
	// ************************************************************
	localparam logic [1:0] AMP_BYPASS = 2'h0;
	localparam logic [1:0] AMP_ON = 2'h1;
	localparam logic [2:0] GAIN_X1 = 3'h0;
	localparam logic [2:0] GAIN_X32 = 3'h5;
	localparam logic [1:0] REF_SEL_EXT0 = 2'h0;
	localparam logic [1:0] REF_SEL_EXT1 = 2'h1;
	localparam logic [1:0] REF_SEL_INT = 2'h2;
	localparam logic [1:0] REF_PWR_OFF = 2'h0;
	localparam logic [1:0] REF_PWR_SLEEPS = 2'h1;
	localparam logic [1:0] REF_PWR_ALWAYS = 2'h2;

	// ************************************************************
	// Controller register map (APB byte addresses)
	// ************************************************************
	localparam logic [7:0] CMD_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] CONV_OFS = 8'h08;
	localparam logic [7:0] CTRL_OFS = 8'h0C;
	localparam int CMD_WRITE_BIT = 16;
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_READY_BIT = 1;
	localparam int ST_REJECT_BIT = 2;
	localparam int CTRL_EXC_BIT = 0;
	localparam int CTRL_SE_BIT = 1;
	localparam int CONV_GO_BIT = 0;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam real CLK_MHZ = 25.0;
	localparam real REF_START_MS = 4.5;
	localparam int REF_WAIT_CYCLES = int'($ceil(REF_START_MS * 1000.0 * CLK_MHZ));
	localparam int REF_CNT_W = 20;

	typedef enum logic [0:0] {
		H_IDLE = 1'b0,
		H_WAIT_READ = 1'b1
	} host_state_type;

endpackage

//--- hdl/afe_cfg_link_if.sv
// Register link between the front-end controller and the converter configuration block
`timescale 1ns/100ps
`default_nettype none
interface afe_cfg_link_if;
	logic wr_en;
	logic rd_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rvalid;

	modport device(input wr_en, input rd_en, input addr, input wdata, output rdata, output rvalid);
	modport host(output wr_en, output rd_en, output addr, output wdata, input rdata, input rvalid);
endinterface
`default_nettype wire

//--- hdl/afe_config_dev.sv
// Converter front-end configuration registers: amplifier gain/enable and reference control
`timescale 1ns/100ps
`default_nettype none
module afe_config_dev (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	afe_cfg_link_if.device link,
	input wire logic power_down_pin,
	output logic amp_powered,
	output logic amp_in_path,
	output logic [2:0] analog_gain_code,
	output logic [1:0] digital_shift,
	output logic ref_use_ext0,
	output logic ref_use_ext1,
	output logic ref_use_internal,
	output logic int_ref_powered
);
	import afe_cfg_pkg::*;

	// ************************************************************
	// Register storage
	// ************************************************************
	logic [7:0] gain_cfg_reg;
	logic [7:0] ref_ctrl_reg;
	logic [7:0] rdata_reg;
	logic rvalid_reg;

	logic [2:0] gain_field;
	logic [1:0] amp_field;
	logic [1:0] ref_sel_field;
	logic [1:0] ref_pwr_field;

	// Power-down request crosses in from a pin
	logic pd_meta_reg;
	logic pd_sync_reg;

	// Decoded front-end controls, all registered
	logic amp_powered_reg;
	logic amp_in_path_reg;
	logic [2:0] analog_gain_reg;
	logic [1:0] digital_shift_reg;
	logic [1:0] ref_route_reg;
	logic int_ref_powered_reg;
	logic [2:0] ref_onehot_reg;

	logic amp_on_next;
	logic [2:0] analog_gain_next;
	logic [1:0] digital_shift_next;
	logic [1:0] ref_route_next;
	logic int_ref_on_next;

	// Field slices of the stored bytes
	assign gain_field = gain_cfg_reg[GAIN_LSB +: 3];
	assign amp_field = gain_cfg_reg[AMP_EN_LSB +: 2];
	assign ref_sel_field = ref_ctrl_reg[REF_SEL_LSB +: 2];
	assign ref_pwr_field = ref_ctrl_reg[REF_PWR_LSB +: 2];

	// ************************************************************
	// Register writes
	// ************************************************************

	// Whole bytes are kept so every written bit reads back as written
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gain_cfg_reg <= GAIN_CFG_RST;
			ref_ctrl_reg <= REF_CTRL_RST;
		end else if (ce && link.wr_en) begin
			if (link.addr == GAIN_CFG_OFS) begin
				gain_cfg_reg <= link.wdata;
			end
			if (link.addr == REF_CTRL_OFS) begin
				ref_ctrl_reg <= link.wdata;
			end
		end
	end

	// ************************************************************
	// Register reads
	// ************************************************************

	// Read data answers one edge after the strobe; unmapped reads give zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
		end else if (ce) begin
			rvalid_reg <= link.rd_en;
			if (link.rd_en) begin
				unique case (link.addr)
					GAIN_CFG_OFS: rdata_reg <= gain_cfg_reg;
					REF_CTRL_OFS: rdata_reg <= ref_ctrl_reg;
					default: rdata_reg <= 8'h00;
				endcase
			end
		end
	end

	assign link.rdata = rdata_reg;
	assign link.rvalid = rvalid_reg;

	// ************************************************************
	// Power-down synchroniser
	// ************************************************************

	// Two stages before use; the pin is asynchronous to clk
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pd_meta_reg <= 1'b0;
			pd_sync_reg <= 1'b0;
		end else if (ce) begin
			pd_meta_reg <= power_down_pin;
			pd_sync_reg <= pd_meta_reg;
		end
	end

	// ************************************************************
	// Amplifier decode
	// ************************************************************

	// Bypass only honoured at unity gain, otherwise the amplifier stays in
	always_comb begin
		amp_on_next = 1'b1;
		if (amp_field == AMP_BYPASS && gain_field == GAIN_X1) begin
			amp_on_next = 1'b0;
		end
	end

	// Top two gains clamp the analog stage at 32 and shift digitally
	always_comb begin
		analog_gain_next = 3'h0;
		digital_shift_next = 2'h0;
		if (amp_on_next) begin
			if (gain_field > GAIN_X32) begin
				analog_gain_next = GAIN_X32;
				digital_shift_next = 2'(gain_field - GAIN_X32);
			end else begin
				analog_gain_next = gain_field;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			amp_powered_reg <= 1'b0;
			amp_in_path_reg <= 1'b0;
			analog_gain_reg <= 3'h0;
			digital_shift_reg <= 2'h0;
		end else if (ce) begin
			amp_powered_reg <= amp_on_next;
			amp_in_path_reg <= amp_on_next;
			analog_gain_reg <= analog_gain_next;
			digital_shift_reg <= digital_shift_next;
		end
	end

	// ************************************************************
	// Reference decode
	// ************************************************************

	// Reserved select code holds the previous routing rather than glitching
	always_comb begin
		ref_route_next = ref_route_reg;
		unique case (ref_sel_field)
			REF_SEL_EXT0: ref_route_next = REF_SEL_EXT0;
			REF_SEL_EXT1: ref_route_next = REF_SEL_EXT1;
			REF_SEL_INT: ref_route_next = REF_SEL_INT;
			default: ref_route_next = ref_route_reg;
		endcase
	end

	// Reserved power code leaves the reference off
	always_comb begin
		int_ref_on_next = 1'b0;
		unique case (ref_pwr_field)
			REF_PWR_ALWAYS: int_ref_on_next = 1'b1;
			REF_PWR_SLEEPS: int_ref_on_next = !pd_sync_reg;
			default: int_ref_on_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ref_route_reg <= REF_SEL_EXT0;
			ref_onehot_reg <= 3'h1;
			int_ref_powered_reg <= 1'b0;
		end else if (ce) begin
			ref_route_reg <= ref_route_next;
			ref_onehot_reg <= {ref_route_next == REF_SEL_INT, ref_route_next == REF_SEL_EXT1,
				ref_route_next == REF_SEL_EXT0};
			int_ref_powered_reg <= int_ref_on_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************

	// Route one-hot is read straight off its own flops, loaded alongside the route register
	assign amp_powered = amp_powered_reg;
	assign amp_in_path = amp_in_path_reg;
	assign analog_gain_code = analog_gain_reg;
	assign digital_shift = digital_shift_reg;
	assign ref_use_ext0 = ref_onehot_reg[0];
	assign ref_use_ext1 = ref_onehot_reg[1];
	assign ref_use_internal = ref_onehot_reg[2];
	assign int_ref_powered = int_ref_powered_reg;

endmodule
`default_nettype wire

//--- hdl/afe_config_host.sv
// Front-end controller: APB registers driving the converter configuration link
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module afe_config_host #(
	parameter int REF_WAIT = afe_cfg_pkg::REF_WAIT_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	afe_cfg_link_if.host link,
	output logic conv_start,
	output logic excitation_enable
);
	import afe_cfg_pkg::*;

	// ************************************************************
	// State
	// ************************************************************
	host_state_type state_reg;
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic wr_en_reg;
	logic rd_en_reg;
	logic [7:0] addr_reg;
	logic [7:0] wdata_reg;
	logic [7:0] last_read_reg;
	logic reject_reg;
	logic exc_reg;
	logic se_reg;
	logic ref_on_reg;
	logic ref_int_sel_reg;
	logic [REF_CNT_W-1:0] ref_cnt_reg;
	logic conv_reg;

	logic access;
	logic cmd_wr;
	logic busy;
	logic ref_ready;
	logic [7:0] cmd_addr;
	logic [7:0] cmd_data;
	logic cmd_bad;
	logic [7:0] send_data;
	logic send_ref_on;

	assign access = psel && penable && pready_reg;
	assign cmd_wr = access && pwrite && paddr == CMD_OFS;
	assign busy = state_reg != H_IDLE || wr_en_reg || rd_en_reg;
	assign ref_ready = ref_on_reg && ref_cnt_reg == '0;
	assign cmd_addr = pwdata[15:8];
	assign cmd_data = pwdata[7:0];

	// ************************************************************
	// Command filtering
	// ************************************************************

	// Writes are reshaped or refused before they reach the device
	always_comb begin
		send_data = cmd_data;
		cmd_bad = busy;
		if (cmd_addr == GAIN_CFG_OFS) begin
			if (se_reg) begin
				send_data[AMP_EN_LSB +: 2] = AMP_BYPASS;
				send_data[GAIN_LSB +: 3] = GAIN_X1;
			end else if (cmd_data[AMP_EN_LSB + 1]) begin
				cmd_bad = 1'b1;
			end
		end
		if (cmd_addr == REF_CTRL_OFS && exc_reg) begin
			if (!(cmd_data[REF_PWR_LSB +: 2] inside {REF_PWR_SLEEPS, REF_PWR_ALWAYS})) begin
				send_data[REF_PWR_LSB +: 2] = REF_PWR_SLEEPS;
			end
		end
		send_ref_on = send_data[REF_PWR_LSB +: 2] inside {REF_PWR_SLEEPS, REF_PWR_ALWAYS};
	end

	// ************************************************************
	// APB slave
	// ************************************************************

	// Ready is raised for the access phase after every setup cycle
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
		end else if (ce) begin
			pready_reg <= psel && !penable && !pready_reg;
			if (psel && !penable) begin
				pslverr_reg <= !(paddr inside {CMD_OFS, STATUS_OFS, CONV_OFS, CTRL_OFS});
				unique case (paddr)
					STATUS_OFS: prdata_reg <= {16'h0000, last_read_reg, 5'h00, reject_reg,
						ref_ready, busy};
					CTRL_OFS: prdata_reg <= {30'h00000000, se_reg, exc_reg};
					default: prdata_reg <= 32'h00000000;
				endcase
			end
		end
	end

	// Control bits; excitation only leaves while the reference is on
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			exc_reg <= 1'b0;
			se_reg <= 1'b0;
		end else if (ce && access && pwrite && paddr == CTRL_OFS) begin
			exc_reg <= pwdata[CTRL_EXC_BIT];
			se_reg <= pwdata[CTRL_SE_BIT];
		end
	end

	// ************************************************************
	// Link sequencer
	// ************************************************************
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_reg <= H_IDLE;
			wr_en_reg <= 1'b0;
			rd_en_reg <= 1'b0;
			addr_reg <= 8'h00;
			wdata_reg <= 8'h00;
			last_read_reg <= 8'h00;
		end else if (ce) begin
			wr_en_reg <= 1'b0;
			rd_en_reg <= 1'b0;
			unique case (state_reg)
				H_IDLE: begin
					if (cmd_wr && !cmd_bad) begin
						addr_reg <= cmd_addr;
						wdata_reg <= send_data;
						wr_en_reg <= pwdata[CMD_WRITE_BIT];
						rd_en_reg <= !pwdata[CMD_WRITE_BIT];
						if (!pwdata[CMD_WRITE_BIT]) begin
							state_reg <= H_WAIT_READ;
						end
					end
				end
				H_WAIT_READ: begin
					if (link.rvalid) begin
						last_read_reg <= link.rdata;
						state_reg <= H_IDLE;
					end
				end
			endcase
		end
	end

	// Refusals stick until software writes one; a new refusal wins
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reject_reg <= 1'b0;
		end else if (ce) begin
			if ((cmd_wr && cmd_bad) || (access && pwrite && paddr == CONV_OFS && pwdata[CONV_GO_BIT]
				&& !ref_ready && ref_int_sel_reg)) begin
				reject_reg <= 1'b1;
			end else if (access && pwrite && paddr == STATUS_OFS && pwdata[ST_REJECT_BIT]) begin
				reject_reg <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Reference start-up tracking
	// ************************************************************

	// Counter restarts only on an off-to-on transition of the reference
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ref_on_reg <= 1'b0;
			ref_int_sel_reg <= 1'b0;
			ref_cnt_reg <= '0;
		end else if (ce) begin
			if (cmd_wr && !cmd_bad && pwdata[CMD_WRITE_BIT] && cmd_addr == REF_CTRL_OFS) begin
				ref_on_reg <= send_ref_on;
				ref_int_sel_reg <= send_data[REF_SEL_LSB +: 2] == REF_SEL_INT;
				if (send_ref_on && !ref_on_reg) begin
					ref_cnt_reg <= REF_CNT_W'(REF_WAIT);
				end else if (!send_ref_on) begin
					ref_cnt_reg <= '0;
				end
			end else if (ref_cnt_reg != '0) begin
				ref_cnt_reg <= ref_cnt_reg - 1'b1;
			end
		end
	end

	// Conversion start withheld until the internal reference has settled
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			conv_reg <= 1'b0;
		end else if (ce) begin
			conv_reg <= access && pwrite && paddr == CONV_OFS && pwdata[CONV_GO_BIT]
				&& (ref_ready || !ref_int_sel_reg);
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	logic exc_out_reg;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			exc_out_reg <= 1'b0;
		end else if (ce) begin
			exc_out_reg <= exc_reg && ref_on_reg;
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign link.wr_en = wr_en_reg;
	assign link.rd_en = rd_en_reg;
	assign link.addr = addr_reg;
	assign link.wdata = wdata_reg;
	assign conv_start = conv_reg;
	assign excitation_enable = exc_out_reg;

endmodule
`default_nettype wire

//--- tb/afe_cfg_asserts.sv
// Assertions on the configuration link between controller and configuration block
`timescale 1ns/100ps
`default_nettype none
module afe_cfg_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rvalid
);
	import afe_cfg_pkg::*;

	// ************************************************************
	// Shadow of what the host last wrote
	// ************************************************************
	logic [7:0] gain_shadow_reg;
	logic [7:0] ref_shadow_reg;

	// Gain byte copy; reset value mirrors the device
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			gain_shadow_reg <= GAIN_CFG_RST;
		end else if (wr_en && addr == GAIN_CFG_OFS) begin
			gain_shadow_reg <= wdata;
		end
	end

	// Reference byte copy
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ref_shadow_reg <= REF_CTRL_RST;
		end else if (wr_en && addr == REF_CTRL_OFS) begin
			ref_shadow_reg <= wdata;
		end
	end

	// ************************************************************
	// Properties
	// ************************************************************
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	rd_answer_a: assert property (rd_en |=> rvalid)
		else $error("link read not answered one cycle later");
	rvalid_cause_a: assert property (rvalid |-> $past(rd_en))
		else $error("read valid without a read strobe");
	rvalid_pulse_a: assert property (rvalid |=> !rvalid)
		else $error("read valid longer than one cycle");
	rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
		else $error("read data moved without a read");
	gain_readback_a: assert property (rd_en && addr == GAIN_CFG_OFS
		|=> rdata == gain_shadow_reg)
		else $error("gain byte read back differs from last write");
	ref_readback_a: assert property (rd_en && addr == REF_CTRL_OFS
		|=> rdata == ref_shadow_reg)
		else $error("reference byte read back differs from last write");
	unmapped_read_a: assert property (rd_en && addr != GAIN_CFG_OFS && addr != REF_CTRL_OFS
		|=> rdata == 8'h00)
		else $error("unmapped link read not zero");
	amp_reserved_a: assert property (wr_en && addr == GAIN_CFG_OFS |-> !wdata[AMP_EN_LSB + 1])
		else $error("reserved amplifier enable code sent");
	// Back-to-back bus commands may leave a single idle cycle between strobes
	strobe_single_a: assert property ((wr_en || rd_en) |=> !(wr_en || rd_en))
		else $error("link strobes too close together");
	strobe_excl_a: assert property (!(wr_en && rd_en))
		else $error("read and write strobes together");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Testbench: APB-driven controller and configuration block joined over their link
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import afe_cfg_pkg::*;
	typedef struct {logic [32:0] exp; logic [32:0] mask;} note_type;
	localparam int WAIT_SIM = 40;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic pd_pin = 1'b0;
	logic ce = 1'b1;
	logic [31:0] prdata;
	logic pready, pslverr, conv_start, exc_en;
	logic amp_powered, amp_in_path, ref_ext0, ref_ext1, ref_int, int_ref_on;
	logic [2:0] gain_code;
	logic [1:0] shift;
	int errors = 0;
	int comparisons = 0;
	int conv_count = 0;
	integer seed = 32'h137E;
	note_type notes[$];
	note_type note_now;

	afe_cfg_link_if afe_cfg_link_if_i ();
	afe_config_host #(.REF_WAIT(WAIT_SIM)) afe_config_host_i (.clk(clk), .rst_b(rst_b), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .link(afe_cfg_link_if_i.host),
		.conv_start(conv_start), .excitation_enable(exc_en));
	afe_config_dev afe_config_dev_i (.clk(clk), .rst_b(rst_b), .ce(ce),
		.link(afe_cfg_link_if_i.device), .power_down_pin(pd_pin), .amp_powered(amp_powered),
		.amp_in_path(amp_in_path), .analog_gain_code(gain_code), .digital_shift(shift),
		.ref_use_ext0(ref_ext0), .ref_use_ext1(ref_ext1), .ref_use_internal(ref_int),
		.int_ref_powered(int_ref_on));
	afe_cfg_asserts afe_cfg_asserts_i (.clk(clk), .rst_b(rst_b), .wr_en(afe_cfg_link_if_i.wr_en),
		.rd_en(afe_cfg_link_if_i.rd_en), .addr(afe_cfg_link_if_i.addr),
		.wdata(afe_cfg_link_if_i.wdata), .rdata(afe_cfg_link_if_i.rdata),
		.rvalid(afe_cfg_link_if_i.rvalid));

	// ************************************************************
	// Clock, monitors and verdict
	// ************************************************************
	initial begin
		forever #20 clk = ~clk;
	end

	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic final_report;
		if (errors == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Oldest note against each completed APB transfer
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (notes.size() == 0) begin
				check("apb note", 33'h0, 33'h1);
			end else begin
				note_now = notes.pop_front();
				check("apb answer", {pslverr, prdata} & note_now.mask,
					note_now.exp & note_now.mask);
			end
		end
	end

	// Pulses are one cycle wide, so count them as they pass
	always @(posedge clk) begin
		if (conv_start === 1'b1) begin
			conv_count++;
		end
	end

	// Cuts a hang short
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		final_report();
	end

	// ************************************************************
	// Bus tasks
	// ************************************************************
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] exp, input logic [32:0] mask, output logic [31:0] r);
		notes.push_back('{exp, mask});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
		logic [31:0] r;
		xfer(1'b1, a, d, {err, 32'h0}, {1'b1, 32'h0}, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
		logic [31:0] r;
		xfer(1'b0, a, 32'h0, {1'b0, exp}, {1'b1, mask}, r);
	endtask

	// Issue one link command and poll status, with no limit of its own, until busy drops
	task automatic cmd(input logic w, input logic [7:0] a, input logic [7:0] d);
		logic [31:0] r;
		wr(CMD_OFS, {15'h0, w, a, d}, 1'b0);
		r = 32'h1;
		while (r[ST_BUSY_BIT] !== 1'b0) begin
			xfer(1'b0, STATUS_OFS, 32'h0, 33'h0, 33'h0, r);
		end
		repeat (3) @(posedge clk);
	endtask

	task automatic dev_rd(input logic [7:0] a, input logic [7:0] exp);
		cmd(1'b0, a, 8'h00);
		rd(STATUS_OFS, {16'h0, exp, 8'h00}, 32'h0000FF00);
	endtask

	function automatic logic [10:0] outs(input logic amp, input logic [2:0] g, input logic [1:0] s,
		input logic [1:0] sel, input logic pw);
		return {amp, amp, g, s, sel == REF_SEL_EXT0, sel == REF_SEL_EXT1, sel == REF_SEL_INT, pw};
	endfunction

	task automatic chk(input logic [10:0] exp);
		check("outputs", {22'h0, amp_powered, amp_in_path, gain_code, shift, ref_ext0, ref_ext1,
			ref_int, int_ref_on}, {22'h0, exp});
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		logic [7:0] b;
		logic [1:0] sel;
		logic [31:0] r;
		int k;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		chk(outs(1'b0, 3'h0, 2'h0, REF_SEL_EXT0, 1'b0));
		dev_rd(GAIN_CFG_OFS, GAIN_CFG_RST);
		dev_rd(REF_CTRL_OFS, REF_CTRL_RST);
		// Conversion refused while the internal reference settles
		cmd(1'b1, REF_CTRL_OFS, {4'h0, REF_SEL_INT, REF_PWR_ALWAYS});
		wr(CONV_OFS, 32'h1, 1'b0);
		rd(STATUS_OFS, 32'h4, 32'h4);
		wr(STATUS_OFS, 32'h4, 1'b0);
		k = 0;
		r = 32'h0;
		while (r[ST_READY_BIT] !== 1'b1 && k < WAIT_SIM) begin
			xfer(1'b0, STATUS_OFS, 32'h0, 33'h0, 33'h0, r);
			k++;
		end
		wr(CONV_OFS, 32'h1, 1'b0);
		rd(STATUS_OFS, 32'h2, 32'h6);
		check("conversion starts", 33'(conv_count), 33'h1);
		// Every gain code with the amplifier on, random stored-only bits
		for (int g = 0; g < 8; g++) begin
			b = {3'($random(seed)), AMP_ON, 3'(g)};
			cmd(1'b1, GAIN_CFG_OFS, b);
			chk(outs(1'b1, g > 5 ? GAIN_X32 : 3'(g), g > 5 ? 2'(g - 5) : 2'h0,
				REF_SEL_INT, 1'b1));
			dev_rd(GAIN_CFG_OFS, b);
		end
		// Bypass only at gain 1
		cmd(1'b1, GAIN_CFG_OFS, {3'h0, AMP_BYPASS, GAIN_X1});
		chk(outs(1'b0, 3'h0, 2'h0, REF_SEL_INT, 1'b1));
		cmd(1'b1, GAIN_CFG_OFS, {3'h0, AMP_BYPASS, 3'h3});
		chk(outs(1'b1, 3'h3, 2'h0, REF_SEL_INT, 1'b1));
		// Reserved amplifier code is refused before it reaches the link
		wr(CMD_OFS, {15'h0, 1'b1, GAIN_CFG_OFS, 8'h10}, 1'b0);
		rd(STATUS_OFS, 32'h4, 32'h4);
		wr(STATUS_OFS, 32'h4, 1'b0);
		chk(outs(1'b1, 3'h3, 2'h0, REF_SEL_INT, 1'b1));
		// Single-ended mode forces gain 1 and bypass
		wr(CTRL_OFS, 32'h2, 1'b0);
		cmd(1'b1, GAIN_CFG_OFS, {3'h0, AMP_ON, 3'h4});
		chk(outs(1'b0, 3'h0, 2'h0, REF_SEL_INT, 1'b1));
		wr(CTRL_OFS, 32'h0, 1'b0);
		// Every reference select and power code
		sel = REF_SEL_INT;
		for (int i = 0; i < 4; i++) begin
			b = {4'($random(seed)), 2'(i), 2'(i)};
			cmd(1'b1, REF_CTRL_OFS, b);
			if (i != 3) begin
				sel = 2'(i);
			end
			chk(outs(1'b0, 3'h0, 2'h0, sel, i == 1 || i == 2));
			dev_rd(REF_CTRL_OFS, b);
		end
		// Power-down pin against the two power codes
		cmd(1'b1, REF_CTRL_OFS, {4'h0, REF_SEL_EXT1, REF_PWR_SLEEPS});
		// Clock enable low freezes the synchroniser, so the reference stays up
		ce <= 1'b0;
		pd_pin <= 1'b1;
		repeat (6) @(posedge clk);
		chk(outs(1'b0, 3'h0, 2'h0, REF_SEL_EXT1, 1'b1));
		ce <= 1'b1;
		repeat (6) @(posedge clk);
		chk(outs(1'b0, 3'h0, 2'h0, REF_SEL_EXT1, 1'b0));
		cmd(1'b1, REF_CTRL_OFS, {4'h0, REF_SEL_EXT1, REF_PWR_ALWAYS});
		chk(outs(1'b0, 3'h0, 2'h0, REF_SEL_EXT1, 1'b1));
		pd_pin <= 1'b0;
		// Excitation keeps the reference powered
		wr(CTRL_OFS, 32'h1, 1'b0);
		cmd(1'b1, REF_CTRL_OFS, {4'h0, REF_SEL_EXT1, REF_PWR_OFF});
		chk(outs(1'b0, 3'h0, 2'h0, REF_SEL_EXT1, 1'b1));
		dev_rd(REF_CTRL_OFS, {4'h0, REF_SEL_EXT1, REF_PWR_SLEEPS});
		check("excitation", {32'h0, exc_en}, 33'h1);
		// Unmapped places on both buses
		wr(8'h10, 32'h0, 1'b1);
		dev_rd(8'h07, 8'h00);
		repeat (4) @(posedge clk);
		final_report();
	end
endmodule
`default_nettype wire
